// ---- hdl/emb_defines.svh ----
// constants of the external memory bus cycle generator
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EMB_OFS_WIDTH        4'h0
`define EMB_OFS_STATES       4'h1
`define EMB_OFS_WAIT_UPPER   4'h2
`define EMB_OFS_WAIT_LOWER   4'h3
`define EMB_OFS_CTRL_UPPER   4'h4
`define EMB_OFS_CTRL_LOWER   4'h5
`define EMB_OFS_STATUS       4'h6
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EMB_BIT_BURST_SEL    7
`define EMB_BIT_BURST_LEN    6
`define EMB_BIT_BURST_CNT    5
`define EMB_BIT_WAIT_EN      0
// ----------------------------------------------------------------------
// power-on values and counts
// ----------------------------------------------------------------------
`define EMB_RST_STATES       8'hFF
`define EMB_RST_WAITS        16'hFFFF
`define EMB_RST_CTRL         8'h00
`define EMB_BURST_LEFT_4     3'h3
`define EMB_BURST_LEFT_8     3'h7
`endif

// ---- hdl/emb_pkg.sv ----
// types of the external memory bus cycle generator
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_BYTE = 2'b00,
    EMB_WORD = 2'b01,
    EMB_LONG = 2'b10
  } emb_size_t;

  // gray codes along idle, t1, t2, wait, t3
  typedef enum logic [2:0] {
    EMB_IDLE = 3'b000,
    EMB_T1   = 3'b001,
    EMB_T2   = 3'b011,
    EMB_TW   = 3'b010,
    EMB_T3   = 3'b110,
    EMB_TB   = 3'b100
  } emb_state_t;

  typedef struct packed {
    logic [23:0] addr;
    emb_size_t   size;
    logic        write;
    logic        ifetch;
    logic [31:0] wdata;
  } emb_req_t;
endpackage : emb_pkg

// ---- hdl/emb_bus_cycles.sv ----
// external bus cycle generator for rom, sram and burst rom areas
`timescale 1ns/1ps
`include "emb_defines.svh"
module emb_bus_cycles
  import emb_pkg::*;
#(
  parameter logic [7:0] WIDTH_RESET = 8'h00
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        manual_reset_n,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire emb_req_t    req,
  output logic             resp_valid,
  output logic [31:0]      resp_rdata,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic [23:0]      mem_addr,
  output logic [3:0]       cs_n,
  output logic             rd_n,
  output logic             upper_write_strobe_n,
  output logic             lower_write_strobe_n,
  output logic [15:0]      data_out,
  output logic             data_oe_hi,
  output logic             data_oe_lo,
  input  wire logic [15:0] data_in,
  input  wire logic        wait_n
);
  // ----------------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------------
  logic rst_meta, rst_n, mrst_meta, mrst_n, wait_meta, wait_sync;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // manual reset and wait pin, two flops each
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mrst_meta <= 1'b1;
      mrst_n    <= 1'b1;
      wait_meta <= 1'b1;
      wait_sync <= 1'b1;
    end else begin
      mrst_meta <= manual_reset_n;
      mrst_n    <= mrst_meta;
      wait_meta <= wait_n;
      wait_sync <= wait_meta;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [7:0]  bus_width_control, access_state_control;
  logic [7:0]  bus_control_upper, bus_control_lower;
  logic [15:0] wait_count;
  logic [7:0]  next_width, next_states, next_ctrl_up, next_ctrl_lo, next_rdata;
  logic [15:0] next_waits;
  emb_state_t  state;
  logic        burst_open;

  // register writes and read data; manual reset leaves all of these alone
  always_comb begin
    next_width   = bus_width_control;
    next_states  = access_state_control;
    next_waits   = wait_count;
    next_ctrl_up = bus_control_upper;
    next_ctrl_lo = bus_control_lower;
    next_rdata   = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        `EMB_OFS_WIDTH:      next_width        = reg_wdata;
        `EMB_OFS_STATES:     next_states       = reg_wdata;
        `EMB_OFS_WAIT_UPPER: next_waits[15:8]  = reg_wdata;
        `EMB_OFS_WAIT_LOWER: next_waits[7:0]   = reg_wdata;
        `EMB_OFS_CTRL_UPPER: next_ctrl_up      = reg_wdata & 8'hE0;
        `EMB_OFS_CTRL_LOWER: next_ctrl_lo      = reg_wdata & 8'h01;
        default:             next_rdata        = 8'h00; // unmapped: ignored
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `EMB_OFS_WIDTH:      next_rdata = bus_width_control;
        `EMB_OFS_STATES:     next_rdata = access_state_control;
        `EMB_OFS_WAIT_UPPER: next_rdata = wait_count[15:8];
        `EMB_OFS_WAIT_LOWER: next_rdata = wait_count[7:0];
        `EMB_OFS_CTRL_UPPER: next_rdata = bus_control_upper;
        `EMB_OFS_CTRL_LOWER: next_rdata = bus_control_lower;
        `EMB_OFS_STATUS:     next_rdata = {3'h0, burst_open, state != EMB_IDLE, state};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  // power-on values only; manual reset not wired here
  // power-on settings
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_width_control    <= WIDTH_RESET;
      access_state_control <= `EMB_RST_STATES;
      wait_count           <= `EMB_RST_WAITS;
      bus_control_upper    <= `EMB_RST_CTRL;
      bus_control_lower    <= `EMB_RST_CTRL;
      reg_rdata            <= 8'h00;
    end else begin
      bus_width_control    <= next_width;
      access_state_control <= next_states;
      wait_count           <= next_waits;
      bus_control_upper    <= next_ctrl_up;
      bus_control_lower    <= next_ctrl_lo;
      reg_rdata            <= next_rdata;
    end
  end

  logic wait_en, burst_sel;
  assign wait_en   = bus_control_lower[`EMB_BIT_WAIT_EN];
  assign burst_sel = bus_control_upper[`EMB_BIT_BURST_SEL];

  // area number of an address: 2-Mbyte areas
  function automatic logic [2:0] area_of(input logic [23:0] a);
    return a[23:21];
  endfunction : area_of

  // ----------------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------------
  emb_state_t  next_state;
  logic [1:0]  wcnt, next_wcnt, left, next_left;
  logic        bcnt, next_bcnt;
  logic [31:0] wbuf, next_wbuf, rbuf, next_rbuf;
  logic        b_write, b_ifetch, b_step2, b_three, b_w8, b_hi, b_lo, b_burst;
  logic        n_write, n_ifetch, n_step2, n_three, n_w8, n_hi, n_lo, n_burst;
  logic        next_open, next_resp_valid, go, last;
  logic [2:0]  blft, next_blft;
  logic [23:0] bnext, next_bnext, next_mem_addr;
  logic [31:0] next_resp_rdata;
  logic [3:0]  next_cs_n;
  logic        next_rd_n, next_uw_n, next_lw_n, next_oe_hi, next_oe_lo;
  logic [15:0] next_data_out;
  logic [2:0]  la_area;
  logic [23:0] la;

  assign req_ready = (state == EMB_IDLE) && mrst_n;

  always_comb begin
    next_state = state;       next_wcnt = wcnt;       next_bcnt = bcnt;
    next_left  = left;        next_wbuf = wbuf;       next_rbuf = rbuf;
    n_write    = b_write;     n_ifetch  = b_ifetch;   n_step2   = b_step2;
    n_three    = b_three;     n_w8      = b_w8;       n_hi      = b_hi;
    n_lo       = b_lo;        n_burst   = b_burst;    next_open = burst_open;
    next_blft  = blft;        next_bnext = bnext;     next_mem_addr = mem_addr;
    next_data_out   = data_out;
    next_resp_valid = 1'b0;
    next_resp_rdata = resp_rdata;
    go   = 1'b0;
    last = 1'b0;
    la   = mem_addr;
    unique case (state)
      EMB_IDLE: if (req_valid && mrst_n) begin
        go       = 1'b1;
        la       = req.addr;
        n_write  = req.write;
        n_ifetch = req.ifetch;
        next_rbuf = 32'h0000_0000;
        // width bit 1 is 8-bit, burst forces 16
        n_w8 = bus_width_control[area_of(req.addr)]
               && !(area_of(req.addr) == 3'h0 && burst_sel);
        unique case (req.size)
          EMB_WORD: begin
            next_wbuf = {req.wdata[15:0], 16'h0000};
            n_step2   = !n_w8;
            next_left = n_w8 ? 2'h1 : 2'h0;
          end
          EMB_LONG: begin
            next_wbuf = req.wdata;
            n_step2   = !n_w8;
            next_left = n_w8 ? 2'h3 : 2'h1;
          end
          default: begin
            next_wbuf = {req.wdata[7:0], 24'h00_0000};
            n_step2   = 1'b0;
            next_left = 2'h0;
          end
        endcase
      end
      EMB_T1: begin
        next_state = EMB_T2;
        next_wcnt = b_three ? wait_count[2*area_of(mem_addr) +: 2] : 2'h0;
      end
      EMB_T2, EMB_TW: begin
        if (!b_three) begin
          last = 1'b1;
        end else if (wcnt != 2'h0) begin
          next_state = EMB_TW;
          next_wcnt  = wcnt - 2'h1;
        end else if (wait_en && !wait_sync) begin
          next_state = EMB_TW;
        end else begin
          next_state = EMB_T3;
        end
      end
      EMB_T3: last = 1'b1;
      EMB_TB: begin
        if (bcnt) begin
          next_bcnt = 1'b0;
        end else begin
          last = 1'b1;
        end
      end
      default: next_state = EMB_IDLE;
    endcase

    // end of last state: take read data, advance the beat
    if (last) begin
      if (b_step2) begin
        next_rbuf = {rbuf[15:0], data_in};
        next_wbuf = {wbuf[15:0], 16'h0000};
      end else begin
        next_rbuf = {rbuf[23:0], b_hi ? data_in[15:8] : data_in[7:0]};
        next_wbuf = {wbuf[23:0], 8'h00};
      end
      if (left == 2'h0) begin
        next_state      = EMB_IDLE;
        next_resp_valid = 1'b1;
        next_resp_rdata = next_rbuf;
      end else begin
        go        = 1'b1;
        la        = mem_addr + (b_step2 ? 24'h00_0002 : 24'h00_0001);
        next_left = left - 2'h1;
      end
    end

    // start of a beat: lanes, timing class and burst tracking
    la_area = area_of(la);
    if (go) begin
      next_mem_addr = la;
      n_hi = n_step2 || n_w8 || !la[0];
      n_lo = n_step2 || (!n_w8 && la[0]);
      next_data_out = n_step2 ? next_wbuf[31:16] : {2{next_wbuf[31:24]}};
      // area state bit picks two or three
      n_three = access_state_control[la_area];
      n_burst = 1'b0;
      if (n_ifetch && la_area == 3'h0 && burst_sel && !n_write) begin
        if (burst_open && la == bnext && blft != 3'h0) begin
          n_burst   = 1'b1;
          next_blft = blft - 3'h1;
        end else begin
          next_open = 1'b1;
          next_blft = bus_control_upper[`EMB_BIT_BURST_CNT] ?
                      `EMB_BURST_LEFT_8 : `EMB_BURST_LEFT_4;
        end
        next_bnext = la + 24'h00_0002;
      end else begin
        next_open = 1'b0;
      end
      next_bcnt  = bus_control_upper[`EMB_BIT_BURST_LEN];
      next_state = n_burst ? EMB_TB : EMB_T1;
    end

    // manual reset aborts any cycle, configuration stays
    if (!mrst_n) begin
      next_state      = EMB_IDLE;
      next_open       = 1'b0;
      next_resp_valid = 1'b0;
    end

    // pin decode from the coming state
    // chip select
    next_cs_n = 4'hF;
    if (next_state != EMB_IDLE && !next_mem_addr[23]) begin
      next_cs_n[next_mem_addr[22:21]] = 1'b0;
    end
    next_rd_n  = !(!n_write && next_state != EMB_IDLE && next_state != EMB_T1);
    next_uw_n  = !(n_write && n_hi && (next_state == EMB_T2 || next_state == EMB_TW));
    next_lw_n  = !(n_write && n_lo && !n_w8
                   && (next_state == EMB_T2 || next_state == EMB_TW));
    next_oe_hi = n_write && n_hi && next_state != EMB_IDLE;
    next_oe_lo = n_write && n_lo && next_state != EMB_IDLE;
  end

  // sequencer and pin registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EMB_IDLE;    wcnt <= 2'h0;     bcnt <= 1'b0;    left <= 2'h0;
      wbuf <= 32'h0000_0000;                  rbuf <= 32'h0000_0000;
      b_write <= 1'b0;      b_ifetch <= 1'b0; b_step2 <= 1'b0; b_three <= 1'b0;
      b_w8 <= 1'b0;         b_hi <= 1'b0;     b_lo <= 1'b0;    b_burst <= 1'b0;
      burst_open <= 1'b0;   blft <= 3'h0;     bnext <= 24'h00_0000;
      resp_valid <= 1'b0;   resp_rdata <= 32'h0000_0000;
      mem_addr <= 24'h00_0000;                cs_n <= 4'hF;
      rd_n <= 1'b1;         upper_write_strobe_n <= 1'b1;
      lower_write_strobe_n <= 1'b1;           data_out <= 16'h0000;
      data_oe_hi <= 1'b0;   data_oe_lo <= 1'b0;
    end else begin
      state <= next_state;  wcnt <= next_wcnt; bcnt <= next_bcnt; left <= next_left;
      wbuf <= next_wbuf;    rbuf <= next_rbuf;
      b_write <= n_write;   b_ifetch <= n_ifetch; b_step2 <= n_step2;
      b_three <= n_three;   b_w8 <= n_w8;     b_hi <= n_hi;    b_lo <= n_lo;
      b_burst <= n_burst;   burst_open <= next_open;
      blft <= next_blft;    bnext <= next_bnext;
      resp_valid <= next_resp_valid;          resp_rdata <= next_resp_rdata;
      mem_addr <= next_mem_addr;              cs_n <= next_cs_n;
      rd_n <= next_rd_n;    upper_write_strobe_n <= next_uw_n;
      lower_write_strobe_n <= next_lw_n;      data_out <= next_data_out;
      data_oe_hi <= next_oe_hi;               data_oe_lo <= next_oe_lo;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !mrst_n);

  sequence three_waits_s;
    (state == EMB_T2) ##1 (state == EMB_TW) [*3] ##1 (state == EMB_T3);
  endsequence

  prog_wait_count_a: assert property (
    (state == EMB_T1 && b_three && !wait_en && !b_burst
     && wait_count[2*area_of(mem_addr) +: 2] == 2'h3) |=> three_waits_s)
    else $error("three programmed waits not inserted");
  two_state_len_a: assert property (
    (state == EMB_T1 && !b_three) |=> (state == EMB_T2) ##1
    (state != EMB_TW && state != EMB_T3))
    else $error("2-state cycle not two states");
  pin_wait_off_a: assert property (
    (state == EMB_T2 && b_three && wcnt == 2'h0 && !wait_en) |=> state == EMB_T3)
    else $error("wait inserted with pin waits disabled");
  burst_no_wait_a: assert property (
    (state == EMB_TB) |=> (state != EMB_TW && state != EMB_T3))
    else $error("wait inserted in burst cycle");
  lower_strobe_8bit_a: assert property (
    !lower_write_strobe_n |-> !b_w8 && b_lo && !data_oe_hi || b_step2)
    else $error("lower write strobe in 8-bit area");
  read_strobe_only_a: assert property (
    !rd_n |-> upper_write_strobe_n && lower_write_strobe_n
    && !data_oe_hi && !data_oe_lo)
    else $error("read strobe with write activity");
  byte_lane_float_a: assert property (
    (state != EMB_IDLE && b_write && !b_step2) |-> !(data_oe_hi && data_oe_lo))
    else $error("both lanes driven on byte write");
  chip_select_a: assert property (
    (state != EMB_IDLE && !mem_addr[23]) |-> cs_n[mem_addr[22:21]] == 1'b0)
    else $error("chip select not low during access");
  por_defaults_a: assert property (
    $rose(rst_n) |-> access_state_control == `EMB_RST_STATES
    && wait_count == `EMB_RST_WAITS && !wait_en)
    else $error("power-on defaults wrong");
endmodule : emb_bus_cycles

// ---- verif/emb_mem_model.sv ----
// behavioural rom, sram and burst rom model on the external data bus
`timescale 1ns/1ps
module emb_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [23:0] mem_addr,
  input  wire logic [3:0]  cs_n,
  input  wire logic        rd_n,
  input  wire logic        upper_write_strobe_n,
  input  wire logic        lower_write_strobe_n,
  input  wire logic [15:0] data_out,
  input  wire logic [3:0]  narrow,
  input  wire logic [7:0]  wait_hold,
  output logic [15:0]      data_in,
  output logic             wait_n
);
  logic [7:0]  mem [0:1023];
  logic [15:0] last = 16'h0000;
  logic [7:0]  act = 8'h00;
  logic [9:0]  ba;
  logic        nar;

  // byte index built from area and low address; byte j holds the low eight bits of j
  assign ba  = {mem_addr[22:21], mem_addr[7:0]};
  assign nar = narrow[mem_addr[22:21]];
  initial begin
    for (int j = 0; j < 1024; j++) mem[j] = 8'(j);
  end

  // byte-wide parts sit on the upper lane; released lines show the inverse of the last value
  always_comb begin
    if (!rd_n && nar) data_in = {mem[ba], ~last[7:0]};
    else if (!rd_n) data_in = {mem[{ba[9:1], 1'b0}], mem[{ba[9:1], 1'b1}]};
    else data_in = ~last;
  end

  // writes land per lane strobe; act counts cycles of the running access
  always @(posedge ref_clk) begin
    if (!rd_n) last <= data_in;
    if (!upper_write_strobe_n) mem[nar ? ba : {ba[9:1], 1'b0}] <= data_out[15:8];
    if (!lower_write_strobe_n) mem[{ba[9:1], 1'b1}] <= data_out[7:0];
    act <= (cs_n == 4'hF) ? 8'h00 : act + 8'h01;
  end

  assign wait_n = (cs_n == 4'hF) || (act >= wait_hold);
endmodule : emb_mem_model

// ---- verif/emb_bus_cycles_tb.sv ----
// self-checking bench for the external memory bus cycle generator
`timescale 1ns/1ps
module emb_bus_cycles_tb;
  import emb_pkg::*;
  typedef struct packed {
    logic [39:0] cfg;
    emb_req_t    rq;
    logic [31:0] rd;
    logic [7:0]  cyc;
    logic [4:0]  fl;
    logic [7:0]  hold;
  } emb_row_t;
  // cfg = width, states, waits lower, control upper, control lower
  localparam logic [39:0] CFG_P = 40'h00_FFFF_0000;
  localparam logic [39:0] CFG_A = 40'h02_0624_0000;
  localparam logic [39:0] CFG_B = 40'h02_0024_0000;
  localparam logic [39:0] CFG_C = 40'h02_0634_0000;
  localparam logic [39:0] CFG_D = 40'h02_0024_0001;
  localparam logic [39:0] CFG_E = 40'h02_0420_0000;
  localparam logic [39:0] CFG_F = 40'h01_0100_A000;
  localparam logic [39:0] CFG_G = 40'h01_0100_C000;
  localparam logic [39:0] CFG_H = 40'h01_0000_8000;
  // two programmed waits cover the two-flop latency of the wait pin
  localparam logic [39:0] CFG_W = 40'h02_0420_0001;
  // seen flags: read, upper write, lower write, upper drive, lower drive
  localparam logic [4:0]  RD = 5'b10000;
  localparam logic [4:0]  WU = 5'b01010;
  localparam logic [4:0]  WW = 5'b01111;
  localparam logic [4:0]  WL = 5'b00101;
  logic        ref_clk, reset_n, manual_reset_n, req_valid, req_ready, resp_valid;
  logic        reg_wr, reg_rd, rd_n, uws_n, lws_n, oe_hi, oe_lo, wait_n;
  emb_req_t    req;
  logic [31:0] resp_rdata;
  logic [3:0]  reg_addr, cs_n;
  logic [7:0]  reg_wdata, reg_rdata, hold;
  logic [23:0] mem_addr;
  logic [15:0] data_out, data_in;
  logic [39:0] cur = CFG_P;
  logic [7:0]  dflt [7] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  int          miscompares = 0;
  int          checked = 0;
  int          cycles;

  function automatic emb_row_t mkrow(logic [39:0] c, logic [23:0] a, emb_size_t s,
                                     logic [1:0] wf, logic [31:0] d, logic [7:0] n,
                                     logic [4:0] fl, logic [7:0] h);
    mkrow = '{c, '{a, s, wf[1], wf[0], d}, d, n, fl, h};
  endfunction : mkrow

  emb_row_t rows [20] = '{
    mkrow(CFG_A, 24'h20_0010, EMB_LONG, 2'b10, 32'h1122_3344, 8'd16, WU, 8'h00),
    mkrow(CFG_A, 24'h20_0010, EMB_LONG, 2'b00, 32'h1122_3344, 8'd16, RD, 8'h00),
    mkrow(CFG_A, 24'h20_0012, EMB_BYTE, 2'b00, 32'h0000_0033, 8'd4, RD, 8'h00),
    mkrow(CFG_B, 24'h40_0020, EMB_WORD, 2'b10, 32'h0000_A55A, 8'd2, WW, 8'h00),
    mkrow(CFG_B, 24'h40_0023, EMB_BYTE, 2'b10, 32'h0000_00C3, 8'd2, WL, 8'h00),
    mkrow(CFG_B, 24'h40_0022, EMB_BYTE, 2'b10, 32'h0000_003C, 8'd2, WU, 8'h00),
    mkrow(CFG_A, 24'h40_0020, EMB_LONG, 2'b00, 32'hA55A_3CC3, 8'd10, RD, 8'h00),
    mkrow(CFG_A, 24'h40_0021, EMB_BYTE, 2'b00, 32'h0000_005A, 8'd5, RD, 8'h00),
    mkrow(CFG_C, 24'h40_0022, EMB_WORD, 2'b00, 32'h0000_3CC3, 8'd6, RD, 8'h00),
    mkrow(CFG_D, 24'h40_0021, EMB_BYTE, 2'b00, 32'h0000_005A, 8'd2, RD, 8'd6),
    mkrow(CFG_E, 24'h40_0024, EMB_BYTE, 2'b00, 32'h0000_0024, 8'd5, RD, 8'd6),
    mkrow(CFG_F, 24'h00_0040, EMB_LONG, 2'b01, 32'h4041_4243, 8'd4, RD, 8'h00),
    mkrow(CFG_F, 24'h00_0044, EMB_LONG, 2'b01, 32'h4445_4647, 8'd2, RD, 8'h00),
    mkrow(CFG_F, 24'h00_0048, EMB_LONG, 2'b01, 32'h4849_4A4B, 8'd2, RD, 8'h00),
    mkrow(CFG_F, 24'h00_004C, EMB_LONG, 2'b01, 32'h4C4D_4E4F, 8'd2, RD, 8'h00),
    mkrow(CFG_G, 24'h00_0080, EMB_LONG, 2'b01, 32'h8081_8283, 8'd5, RD, 8'h00),
    mkrow(CFG_G, 24'h00_0084, EMB_LONG, 2'b00, 32'h8485_8687, 8'd6, RD, 8'h00),
    mkrow(CFG_H, 24'h00_00C0, EMB_LONG, 2'b01, 32'hC0C1_C2C3, 8'd3, RD, 8'h00),
    mkrow(CFG_H, 24'h00_00C4, EMB_LONG, 2'b01, 32'hC4C5_C6C7, 8'd2, RD, 8'h00),
    mkrow(CFG_H, 24'h00_00C8, EMB_LONG, 2'b01, 32'hC8C9_CACB, 8'd3, RD, 8'h00)
  };

  emb_bus_cycles dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .manual_reset_n(manual_reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .cs_n(cs_n), .rd_n(rd_n),
    .upper_write_strobe_n(uws_n), .lower_write_strobe_n(lws_n), .data_out(data_out),
    .data_oe_hi(oe_hi), .data_oe_lo(oe_lo), .data_in(data_in), .wait_n(wait_n));
  emb_mem_model mem_u (.ref_clk(ref_clk), .mem_addr(mem_addr), .cs_n(cs_n), .rd_n(rd_n),
    .upper_write_strobe_n(uws_n), .lower_write_strobe_n(lws_n), .data_out(data_out),
    .narrow(4'b0010), .wait_hold(hold), .data_in(data_in), .wait_n(wait_n));

  task automatic check_value(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_value

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    check_value("register", {24'h0, e}, {24'h0, reg_rdata});
  endtask : reg_check

  // program changed settings, run one transfer, count chip-select cycles and collect the strobes seen
  task automatic xfer(input emb_row_t r);
    int         c;
    logic [8:0] f;
    c = 0;
    f = 9'h000;
    if (r.cfg !== cur) begin
      for (int k = 0; k < 5; k++) reg_write(4'(k + (k > 1)), r.cfg[39 - 8 * k -: 8]);
      cur = r.cfg;
    end
    hold <= r.hold;
    req <= r.rq;
    req_valid <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      if (req_ready === 1'b1) break;
    end
    check_value("request taken", 32'h1, {31'h0, req_ready});
    req_valid <= 1'b0;
    repeat (300) begin
      @(posedge ref_clk);
      if (resp_valid === 1'b1) break;
      if (cs_n !== 4'hF) c++;
      f = f | {~cs_n, ~rd_n, ~uws_n, ~lws_n, oe_hi, oe_lo};
    end
    check_value("response", 32'h1, {31'h0, resp_valid});
    cycles = c;
    if (r.cyc != 8'd0) check_value("cycles", 32'(r.cyc), 32'(c));
    check_value("pins", {23'h0, 4'b0001 << r.rq.addr[22:21], r.fl}, {23'h0, f});
    if (!r.rq.write) check_value("read data", r.rd, resp_rdata);
  endtask : xfer

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  initial begin
    reset_n = 1'b0;
    manual_reset_n = 1'b1;
    req_valid = 1'b0;
    req = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hold = 8'h00;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 7; k++) reg_check(4'(k), dflt[k]);
    reg_write(4'hF, 8'h5A);
    reg_check(4'hF, 8'h00);
    xfer(mkrow(CFG_P, 24'h40_0030, EMB_BYTE, 2'b00, 32'h0000_0030, 8'd6, RD, 8'h00));
    foreach (rows[i]) xfer(rows[i]);
    xfer(mkrow(CFG_W, 24'h40_0031, EMB_BYTE, 2'b00, 32'h0000_0031, 8'd0, RD, 8'd6));
    check_range("pin wait cycles", 6, 14, cycles);
    manual_reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    manual_reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_check(4'h1, 8'h04);
    reg_check(4'h5, 8'h01);
    reg_check(4'h3, 8'h20);
    xfer(mkrow(CFG_W, 24'h40_0025, EMB_BYTE, 2'b00, 32'h0000_0025, 8'd5, RD, 8'h00));
    complete_run();
  end
endmodule : emb_bus_cycles_tb
